// *** hw/capture_timer.sv ***
`timescale 1ns/10ps
module capture_timer
    import capture_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        capture_event_in,
    input  wire logic        count_event_in,
    input  wire logic [1:0]  wf_clk_tick,
    input  wire logic [1:0]  wf_restart,
    input  wire logic        standby_sleep,
    input  wire logic        debug_halt,
    output logic             latch_event_flag_event_out,
    output logic             wrap_event_out,
    output logic             wave_out,
    output logic             wave_oe,
    output logic             counter_running
);
    logic [7:0]  control_a;
    logic [7:0]  control_b;
    logic [7:0]  event_control;
    logic [7:0]  irq_enable_reg;
    logic [7:0]  halt_behaviour_reg;
    logic [7:0]  high_byte_buffer;
    logic [1:0]  irq_flag_reg;
    logic [15:0] count_value;
    logic [15:0] compare_capture_value;
    logic [15:0] next_cnt;
    logic [15:0] next_compare_capture_value;
    logic        next_run;
    fpw_t        fpw;
    fpw_t        next_fpw;
    logic [31:0] next_rdata;
    logic [3:0]  idx;
    logic        started;
    logic        wr_hit;
    logic        rd_hit;
    logic [2:0]  clk_sel;
    logic [2:0]  mode;
    logic        active;
    logic        div2;
    logic        cnt_ev_q;
    logic        tick;
    logic        restart_sel;
    logic [NF_SAMPLES-1:0] nf_hist;
    logic        nf_level;
    logic        sel_lvl;
    logic        dly_lvl;
    logic        ev_lvl;
    logic        prev_lvl;
    logic        act;
    logic        opp;
    logic        set_latch_event_flag;
    logic        set_wrap;
    logic        latch_event_flag_mode;

    assign idx     = address[ADDR_IDX_MSB:ADDR_IDX_LSB];
    assign wr_hit  = write & ~waitrequest & byteenable[0];
    assign rd_hit  = read & ~waitrequest;
    assign clk_sel = control_a[CA_CLK_MSB:CA_CLK_LSB];
    assign mode    = control_b[CB_MODE_MSB:0];
    assign latch_event_flag_mode = (mode >= MODE_LATCH_EVENT_FLAG) && (mode <= MODE_FREQ_AND_WIDTH_MODE);
    assign active  = control_a[CA_ENABLE]
        & (~standby_sleep | control_a[CA_STDBY])
        & (~debug_halt | halt_behaviour_reg[DBG_RUN]);

    // Bus handshake: one wait cycle, then accept
    always_ff @(posedge clk)
    begin
        if (rst)
            waitrequest <= 1'b1;
        else
            waitrequest <= ~((read | write) & waitrequest);
    end

    always_comb
    begin
        next_rdata = '0;
        case (idx)
            IDX_CTRL_A:  next_rdata[7:0] = control_a;
            IDX_CTRL_B:  next_rdata[7:0] = control_b;
            IDX_EV_CTRL: next_rdata[7:0] = event_control;
            IDX_IRQ_EN:  next_rdata[7:0] = irq_enable_reg;
            IDX_FLAGS:   next_rdata[1:0] = irq_flag_reg;
            IDX_STATUS:  next_rdata[0]   = counter_running;
            IDX_DBG:     next_rdata[7:0] = halt_behaviour_reg;
            IDX_TEMP:    next_rdata[7:0] = high_byte_buffer;
            IDX_CNT_LO:  next_rdata[7:0] = count_value[7:0];
            IDX_CNT_HI:  next_rdata[7:0] = high_byte_buffer;
            IDX_COMPARE_CAPTURE_VALUE_LO: next_rdata[7:0] = compare_capture_value[7:0];
            IDX_COMPARE_CAPTURE_VALUE_HI: next_rdata[7:0] = high_byte_buffer;
            default:     next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            readdata <= '0;
        else if ((read | write) & waitrequest)
            readdata <= next_rdata;
    end

    // Configuration registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            control_a          <= RST_REG;
            control_b          <= RST_REG;
            event_control      <= RST_REG;
            irq_enable_reg     <= RST_REG;
            halt_behaviour_reg <= RST_REG;
        end
        else if (wr_hit)
        begin
            case (idx)
                IDX_CTRL_A:  control_a <= writedata[7:0] & MASK_CTRL_A;
                IDX_CTRL_B:  control_b <= writedata[7:0] & MASK_CTRL_B;
                IDX_EV_CTRL: event_control <= writedata[7:0] & MASK_EV_CTRL;
                IDX_IRQ_EN:  irq_enable_reg <= writedata[7:0] & MASK_IRQ;
                IDX_DBG:     halt_behaviour_reg <= writedata[7:0] & MASK_DBG;
                default:     control_a <= control_a;
            endcase
        end
    end

    // Byte buffer for 16-bit access
    always_ff @(posedge clk)
    begin
        if (rst)
            high_byte_buffer <= RST_REG;
        else if (wr_hit && (idx == IDX_TEMP || idx == IDX_CNT_LO
                            || idx == IDX_COMPARE_CAPTURE_VALUE_LO))
            high_byte_buffer <= writedata[7:0];
        else if (rd_hit && idx == IDX_CNT_LO)
            high_byte_buffer <= count_value[15:8];
        else if (rd_hit && idx == IDX_COMPARE_CAPTURE_VALUE_LO)
            high_byte_buffer <= compare_capture_value[15:8];
    end

    // Count tick selection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div2     <= 1'b0;
            cnt_ev_q <= 1'b0;
        end
        else
        begin
            div2     <= active ? ~div2 : 1'b0;
            cnt_ev_q <= count_event_in;
        end
    end

    always_comb
    begin
        case (clk_sel)
            CLK_DIV1:  tick = 1'b1;
            CLK_DIV2:  tick = div2;
            CLK_WF0:   tick = wf_clk_tick[0];
            CLK_WF1:   tick = wf_clk_tick[1];
            CLK_EVENT: tick = count_event_in & ~cnt_ev_q;
            default:   tick = 1'b0;
        endcase
    end

    assign restart_sel = (clk_sel == CLK_WF1) ? wf_restart[1]
                                              : wf_restart[0];

    // Capture input: noise canceller, chain delay, edge detect
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nf_hist  <= '0;
            nf_level <= 1'b0;
            dly_lvl  <= 1'b0;
            prev_lvl <= 1'b0;
        end
        else
        begin
            nf_hist <= {nf_hist[NF_SAMPLES-2:0], capture_event_in};
            if (&nf_hist || ~|nf_hist)
                nf_level <= nf_hist[0];
            dly_lvl  <= sel_lvl;
            prev_lvl <= ev_lvl;
        end
    end

    assign sel_lvl = event_control[EV_FILTER] ? nf_level
                                              : capture_event_in;
    assign ev_lvl  = control_a[CA_CHAIN] ? dly_lvl : sel_lvl;
    assign act = event_control[EV_LATCH_EVENT_FLAG_EN] & active
        & (event_control[EV_EDGE] ? (prev_lvl & ~ev_lvl)
                                  : (ev_lvl & ~prev_lvl));
    assign opp = event_control[EV_LATCH_EVENT_FLAG_EN] & active
        & (event_control[EV_EDGE] ? (ev_lvl & ~prev_lvl)
                                  : (prev_lvl & ~ev_lvl));

    // Counting and mode behaviour
    always_comb
    begin
        next_cnt  = count_value;
        next_compare_capture_value = compare_capture_value;
        next_run  = started;
        next_fpw  = fpw;
        set_latch_event_flag  = 1'b0;
        set_wrap  = 1'b0;
        if (!control_a[CA_ENABLE])
        begin
            next_run = 1'b0;
            next_fpw = FPW_IDLE;
        end
        else
        begin
            case (mode)
                MODE_TIMEOUT:
                    if (act)
                        next_run = 1'b1;
                    else if (opp)
                        next_run = 1'b0;
                MODE_SINGLE:
                    if (act || (event_control[EV_EDGE] && opp))
                        next_run = 1'b1;
                MODE_FREQ_AND_WIDTH_MODE:
                    next_run = (fpw != FPW_IDLE);
                default:
                    next_run = 1'b1;
            endcase
            if (started && tick && active)
            begin
                next_cnt = count_value + 16'h0001;
                set_wrap = (count_value == CNT_MAX);
                if ((mode == MODE_INT || mode == MODE_TIMEOUT
                     || mode == MODE_SINGLE)
                    && count_value == compare_capture_value)
                begin
                    next_cnt = CNT_ZERO;
                    set_latch_event_flag = 1'b1;
                    if (mode == MODE_SINGLE)
                        next_run = 1'b0;
                end
                if (mode == MODE_EIGHT_BIT_PWM_MODE
                    && count_value[7:0] == compare_capture_value[7:0])
                    next_cnt = CNT_ZERO;
            end
            case (mode)
                MODE_LATCH_EVENT_FLAG:
                    if (act)
                    begin
                        next_compare_capture_value = count_value;
                        set_latch_event_flag  = 1'b1;
                    end
                MODE_FRQ:
                    if (act)
                    begin
                        next_compare_capture_value = count_value;
                        next_cnt  = CNT_ZERO;
                        set_latch_event_flag  = 1'b1;
                    end
                MODE_PW:
                    if (opp)
                    begin
                        next_compare_capture_value = count_value;
                        set_latch_event_flag  = 1'b1;
                    end
                    else if (act)
                        next_cnt = CNT_ZERO;
                MODE_FREQ_AND_WIDTH_MODE:
                    case (fpw)
                        FPW_IDLE:
                            if (act)
                            begin
                                next_cnt = CNT_ZERO;
                                next_run = 1'b1;
                                next_fpw = FPW_FIRST;
                            end
                        FPW_FIRST:
                            if (opp)
                            begin
                                next_compare_capture_value = count_value;
                                next_fpw  = FPW_SECOND;
                            end
                        FPW_SECOND:
                            if (act)
                            begin
                                next_run = 1'b0;
                                set_latch_event_flag = 1'b1;
                                next_fpw = FPW_IDLE;
                            end
                        default:
                            next_fpw = FPW_IDLE;
                    endcase
                default:
                    next_compare_capture_value = compare_capture_value;
            endcase
            if (active && control_a[CA_SYNC] && restart_sel)
                next_cnt = CNT_ZERO;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_value           <= CNT_ZERO;
            compare_capture_value <= CNT_ZERO;
            counter_running       <= 1'b0;
            started               <= 1'b0;
            fpw                   <= FPW_IDLE;
        end
        else
        begin
            // Status reads zero while standby or debug gating holds it
            started         <= next_run;
            counter_running <= next_run & active;
            fpw             <= next_fpw;
            if (wr_hit && idx == IDX_CNT_HI)
                count_value <= {writedata[7:0], high_byte_buffer};
            else
                count_value <= next_cnt;
            if (wr_hit && idx == IDX_COMPARE_CAPTURE_VALUE_HI)
                compare_capture_value <= {writedata[7:0],
                                          high_byte_buffer};
            else
                compare_capture_value <= next_compare_capture_value;
        end
    end

    // Flags and event outputs, a set beats a clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_flag_reg   <= '0;
            latch_event_flag_event_out <= 1'b0;
            wrap_event_out <= 1'b0;
        end
        else
        begin
            latch_event_flag_event_out <= set_latch_event_flag;
            wrap_event_out <= set_wrap;
            if (set_wrap)
                irq_flag_reg[FLAG_WRAP] <= 1'b1;
            else if (wr_hit && idx == IDX_FLAGS && writedata[FLAG_WRAP])
                irq_flag_reg[FLAG_WRAP] <= 1'b0;
            if (set_latch_event_flag)
                irq_flag_reg[FLAG_LATCH_EVENT_FLAG] <= 1'b1;
            else if ((wr_hit && idx == IDX_FLAGS && writedata[FLAG_LATCH_EVENT_FLAG])
                     || (rd_hit && latch_event_flag_mode && idx == IDX_COMPARE_CAPTURE_VALUE_LO))
                irq_flag_reg[FLAG_LATCH_EVENT_FLAG] <= 1'b0;
        end
    end

    // Pin output
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wave_out <= 1'b0;
            wave_oe  <= 1'b0;
        end
        else
        begin
            wave_oe <= control_b[CB_OUT_EN];
            if (!control_a[CA_ENABLE])
                wave_out <= (mode == MODE_EIGHT_BIT_PWM_MODE || mode == MODE_SINGLE)
                            ? 1'b0 : control_b[CB_PIN_INIT];
            else if (mode == MODE_EIGHT_BIT_PWM_MODE)
                wave_out <= count_value[7:0] < compare_capture_value[15:8];
            else if (mode == MODE_SINGLE)
            begin
                if (control_b[CB_IMMEDIATE_OUTPUT_ENABLE] && (act
                    || (event_control[EV_EDGE] && opp)))
                    wave_out <= 1'b1;
                else if (next_run && !started)
                    wave_out <= 1'b1;
                else if (started && !next_run)
                    wave_out <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_halt_when_off: assert property (
        !control_a[CA_ENABLE] |=> !counter_running)
        else $error("counter runs while disabled");
    chk_standby_freeze: assert property (
        standby_sleep && !control_a[CA_STDBY] && !wr_hit
        |=> count_value == $past(count_value))
        else $error("counter moved in standby");
    chk_chain_delay: assert property (
        control_a[CA_CHAIN] && !event_control[EV_FILTER]
        && !$past(event_control[EV_FILTER])
        |-> ev_lvl == $past(capture_event_in))
        else $error("chain delay wrong");
    chk_sync_restart: assert property (
        active && control_a[CA_SYNC] && restart_sel && !wr_hit
        |=> count_value == CNT_ZERO)
        else $error("restart sync missed");
    chk_div1_count: assert property (
        active && counter_running && clk_sel == CLK_DIV1
        && mode == MODE_LATCH_EVENT_FLAG && !act && !wr_hit
        && !control_a[CA_SYNC]
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("divide-by-one count wrong");
    chk_filter_stable: assert property (
        $changed(nf_level)
        |-> $past(nf_hist) == '1 || $past(nf_hist) == '0)
        else $error("filter accepted unstable input");
    chk_latch_event_flag_gate: assert property (
        !event_control[EV_LATCH_EVENT_FLAG_EN] |-> !act && !opp)
        else $error("capture acted while disabled");
    chk_wrap_flag: assert property (
        set_wrap |=> irq_flag_reg[FLAG_WRAP] && wrap_event_out)
        else $error("wrap flag not set");
    chk_pin_drive: assert property (
        ##1 wave_oe == $past(control_b[CB_OUT_EN]))
        else $error("pin enable does not follow control");
    chk_pwm_init_low: assert property (
        mode == MODE_EIGHT_BIT_PWM_MODE && !control_a[CA_ENABLE] |=> !wave_out)
        else $error("initial level used in PWM");

    cov_freq_capture: cover property (mode == MODE_FRQ && act);
    cov_wrap: cover property (set_wrap);
    cov_single_start: cover property (mode == MODE_SINGLE && act);
    cov_chain_capture: cover property (control_a[CA_CHAIN] && set_latch_event_flag);
endmodule

// *** pkg/capture_timer_pkg.sv ***
package capture_timer_pkg;
    // Register indices, byte address is four times the index
    localparam logic [3:0] IDX_CTRL_A   = 4'h0;
    localparam logic [3:0] IDX_CTRL_B   = 4'h1;
    localparam logic [3:0] IDX_EV_CTRL  = 4'h4;
    localparam logic [3:0] IDX_IRQ_EN   = 4'h5;
    localparam logic [3:0] IDX_FLAGS    = 4'h6;
    localparam logic [3:0] IDX_STATUS   = 4'h7;
    localparam logic [3:0] IDX_DBG      = 4'h8;
    localparam logic [3:0] IDX_TEMP     = 4'h9;
    localparam logic [3:0] IDX_CNT_LO   = 4'ha;
    localparam logic [3:0] IDX_CNT_HI   = 4'hb;
    localparam logic [3:0] IDX_COMPARE_CAPTURE_VALUE_LO  = 4'hc;
    localparam logic [3:0] IDX_COMPARE_CAPTURE_VALUE_HI  = 4'hd;
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 5;
    // Field positions
    localparam int CA_ENABLE    = 0;
    localparam int CA_CLK_LSB   = 1;
    localparam int CA_CLK_MSB   = 3;
    localparam int CA_SYNC      = 4;
    localparam int CA_CHAIN     = 5;
    localparam int CA_STDBY     = 6;
    localparam int CB_MODE_MSB  = 2;
    localparam int CB_OUT_EN    = 4;
    localparam int CB_PIN_INIT  = 5;
    localparam int CB_IMMEDIATE_OUTPUT_ENABLE     = 6;
    localparam int EV_LATCH_EVENT_FLAG_EN   = 0;
    localparam int EV_EDGE      = 4;
    localparam int EV_FILTER    = 6;
    localparam int FLAG_LATCH_EVENT_FLAG    = 0;
    localparam int FLAG_WRAP    = 1;
    localparam int DBG_RUN      = 0;
    // Reset values and writable masks
    localparam logic [7:0] RST_REG      = 8'h00;
    localparam logic [7:0] MASK_CTRL_A  = 8'h7f;
    localparam logic [7:0] MASK_CTRL_B  = 8'h77;
    localparam logic [7:0] MASK_EV_CTRL = 8'h51;
    localparam logic [7:0] MASK_IRQ     = 8'h03;
    localparam logic [7:0] MASK_DBG     = 8'h01;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam int NF_SAMPLES = 4;
    // Clock source codes
    localparam logic [2:0] CLK_DIV1  = 3'h0;
    localparam logic [2:0] CLK_DIV2  = 3'h1;
    localparam logic [2:0] CLK_WF0   = 3'h2;
    localparam logic [2:0] CLK_WF1   = 3'h3;
    localparam logic [2:0] CLK_EVENT = 3'h7;
    // Timer mode codes
    localparam logic [2:0] MODE_INT     = 3'h0;
    localparam logic [2:0] MODE_TIMEOUT = 3'h1;
    localparam logic [2:0] MODE_LATCH_EVENT_FLAG    = 3'h2;
    localparam logic [2:0] MODE_FRQ     = 3'h3;
    localparam logic [2:0] MODE_PW      = 3'h4;
    localparam logic [2:0] MODE_FREQ_AND_WIDTH_MODE   = 3'h5;
    localparam logic [2:0] MODE_SINGLE  = 3'h6;
    localparam logic [2:0] MODE_EIGHT_BIT_PWM_MODE    = 3'h7;
    typedef enum logic [1:0] {FPW_IDLE, FPW_FIRST, FPW_SECOND} fpw_t;
endpackage

// *** test/event_net.sv ***
`timescale 1ns/10ps
module event_net
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       fire,
    input  wire logic [3:0] len,
    input  wire logic       wave_out,
    input  wire logic       wave_oe,
    output logic            capture_event_in,
    output logic            count_event_in,
    output logic      [1:0] wf_clk_tick,
    output logic      [1:0] wf_restart,
    output logic            pin
);
    logic [3:0] hold;
    logic [5:0] div;
    // Capture level stays high for len cycles after a request
    always_ff @(posedge clk)
    begin
        if (rst)
            hold <= 4'h0;
        else if (fire)
            hold <= len;
        else if (hold != 4'h0)
            hold <= hold - 4'h1;
    end
    assign capture_event_in = (hold != 4'h0);
    // Companion timer ticks, restarts and count events
    always_ff @(posedge clk)
    begin
        if (rst)
            div <= 6'h00;
        else
            div <= div + 6'h01;
    end
    assign wf_clk_tick    = {div[1:0] == 2'h3, div[0]};
    assign wf_restart     = {div == 6'h3f, div == 6'h1f};
    assign count_event_in = div[2];
    // Port logic drives low unless the timer owns the pin
    assign pin = wave_oe ? wave_out : 1'b0;
endmodule

// *** test/test_capture_timer_control_registers.sv ***
`timescale 1ns/10ps
module test_capture_timer_control_registers
    import capture_timer_pkg::*;
();
    logic        clk, rst, read, write, fire, pin;
    logic        capture_event_in, count_event_in, standby_sleep, debug_halt;
    logic        latch_event_flag_event_out, wrap_event_out, wave_out, wave_oe;
    logic        waitrequest, counter_running;
    logic [1:0]  wf_clk_tick, wf_restart;
    logic [3:0]  len;
    logic [5:0]  address;
    logic [31:0] writedata, readdata;
    logic [7:0]  q, r;
    int          mismatches, checks, wraps, capts;
    logic [7:0]  mask [16] = '{8'h7f, 8'h77, 8'h00, 8'h00, 8'h51, 8'h03,
        8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0]  list [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};

    capture_timer u_dut (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
        .capture_event_in(capture_event_in), .count_event_in(count_event_in),
        .wf_clk_tick(wf_clk_tick), .wf_restart(wf_restart),
        .standby_sleep(standby_sleep), .debug_halt(debug_halt),
        .latch_event_flag_event_out(latch_event_flag_event_out), .wrap_event_out(wrap_event_out),
        .wave_out(wave_out), .wave_oe(wave_oe),
        .counter_running(counter_running));
    event_net u_net (.clk(clk), .rst(rst), .fire(fire), .len(len),
        .wave_out(wave_out), .wave_oe(wave_oe),
        .capture_event_in(capture_event_in), .count_event_in(count_event_in),
        .wf_clk_tick(wf_clk_tick), .wf_restart(wf_restart), .pin(pin));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        wraps += int'(wrap_event_out === 1'b1);
        capts += int'(latch_event_flag_event_out === 1'b1);
    end

    task automatic conclude();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access, held until waitrequest is seen low
    task automatic acc(input bit wr, input logic [3:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= {idx, 2'b00};
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= !wr;
        // Waitrequest is sampled at rising edges only
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0)
        begin
            mismatches++;
            $display("[ERR] %0t bus access hung", $time);
            conclude();
        end
        q = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask
    task automatic pulse(input logic [3:0] n);
        @(posedge clk);
        fire <= 1'b1;
        len  <= n;
        @(posedge clk);
        fire <= 1'b0;
        repeat (16) @(posedge clk);
    endtask

    initial
    begin
        void'($urandom(32'h9809));
        {rst, read, write, fire, standby_sleep, debug_halt} = 6'h20;
        address = 6'h00;
        writedata = 32'h0;
        len = 4'h0;
        {mismatches, checks, wraps, capts} = 128'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) rd(4'(i), 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            r = 8'($urandom);
            acc(1'b1, list[i], r);
            rd(list[i], r & mask[list[i]]);
        end
        acc(1'b1, IDX_CTRL_A, 8'h00);
        acc(1'b1, IDX_STATUS, 8'hff);
        rd(IDX_STATUS, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            acc(1'b1, IDX_CTRL_B, 8'(m));
            rd(IDX_CTRL_B, 8'(m));
            acc(1'b1, IDX_CTRL_A, {4'h0, 3'(m), 1'b0});
            rd(IDX_CTRL_A, {4'h0, 3'(m), 1'b0});
        end
        acc(1'b1, IDX_EV_CTRL, 8'h00);
        acc(1'b1, IDX_CTRL_B, {5'h0, MODE_LATCH_EVENT_FLAG});
        acc(1'b1, IDX_CNT_LO, 8'hf0);
        acc(1'b1, IDX_CNT_HI, 8'hff);
        rd(IDX_CNT_LO, 8'hf0);
        rd(IDX_CNT_HI, 8'hff);
        acc(1'b1, IDX_FLAGS, 8'h03);
        acc(1'b1, IDX_DBG, 8'h00);
        wraps = 0;
        capts = 0;
        acc(1'b1, IDX_CTRL_A, 8'h01);
        repeat (30) @(posedge clk);
        rd(IDX_FLAGS, 8'h02);
        chk(8'(wraps), 8'h01);
        rd(IDX_STATUS, 8'h01);
        standby_sleep <= 1'b1;
        rd(IDX_STATUS, 8'h00);
        acc(1'b1, IDX_CTRL_A, 8'h41);
        rd(IDX_STATUS, 8'h01);
        standby_sleep <= 1'b0;
        debug_halt <= 1'b1;
        rd(IDX_STATUS, 8'h00);
        acc(1'b1, IDX_DBG, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h0, counter_running}, 8'h01);
        debug_halt <= 1'b0;
        acc(1'b1, IDX_FLAGS, 8'h02);
        rd(IDX_FLAGS, 8'h00);
        pulse(4'h8);
        rd(IDX_FLAGS, 8'h00);
        acc(1'b1, IDX_EV_CTRL, 8'h01);
        pulse(4'h2);
        rd(IDX_FLAGS, 8'h01);
        chk(8'(capts), 8'h01);
        acc(1'b0, IDX_COMPARE_CAPTURE_VALUE_LO, 8'h00);
        rd(IDX_FLAGS, 8'h00);
        acc(1'b1, IDX_EV_CTRL, 8'h41);
        pulse(4'h2);
        rd(IDX_FLAGS, 8'h00);
        pulse(4'h8);
        rd(IDX_FLAGS, 8'h01);
        acc(1'b1, IDX_FLAGS, 8'h01);
        acc(1'b1, IDX_EV_CTRL, 8'h01);
        acc(1'b1, IDX_CTRL_A, 8'h21);
        pulse(4'h2);
        rd(IDX_FLAGS, 8'h01);
        chk(8'(capts), 8'h03);
        acc(1'b1, IDX_CTRL_A, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h0, counter_running}, 8'h00);
        acc(1'b1, IDX_CTRL_B, 8'h30);
        repeat (3) @(posedge clk);
        chk({5'h0, wave_oe, wave_out, pin}, 8'h07);
        acc(1'b1, IDX_CTRL_B, 8'h20);
        repeat (3) @(posedge clk);
        chk({6'h0, wave_oe, pin}, 8'h00);
        conclude();
    end
endmodule
